// *** core/fdsk_seq_core.sv ***
// Seek, recalibrate, sense and scan sequencer with specify timers.
// Assumes APB master, drive lines and scan events synchronous to pclk.
`timescale 1ns/10ps
module fdsk_seq_core #(
   parameter int MS_CYC = fdsk_pkg::MS_CYCLES,
   parameter int FM_OVR_CYC = fdsk_pkg::FM_OVR_CYCLES,
   parameter int MFM_OVR_CYC = fdsk_pkg::MFM_OVR_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] track_zero,
   input wire fdsk_pkg::fdsk_scan_ev_t scan_ev,
   input wire logic rw_req,
   input wire logic rw_done,
   output logic [3:0] step_out,
   output logic [3:0] dir_out,
   output logic irq,
   output logic dma_req,
   output logic [7:0] comp_byte,
   output logic comp_valid,
   output logic [7:0] scan_sector,
   output logic head_load,
   output logic rw_go
);
   import fdsk_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   fdsk_ctrl_t ctrl_ff;
   fdsk_phase_t phase_ff;
   logic [31:0] result_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff, accept_ff;
   logic [7:0] pcn_ff [NUM_DRIVES];
   logic [7:0] ncn_ff [NUM_DRIVES];
   logic [7:0] cnt_ff [NUM_DRIVES];
   logic [3:0] active_ff, recal_ff, seeking_ff, pend_ff, abn_ff, step_ff, dir_ff;
   logic ready_pend_ff, data_irq_ff, irq_ff;
   logic [17:0] div_ff;
   logic half_ff, ms_tick_ff, step_tick_ff;
   logic [4:0] step_cnt_ff;
   logic [7:0] cur_ff, final_ff, st2_ff;
   logic [1:0] inc_ff;
   logic skip_ff, waiting_ff, dma_req_ff, comp_valid_ff;
   logic [7:0] comp_byte_ff;
   logic [15:0] ovr_cnt_ff;
   logic [7:0] hut_cnt_ff, hl_cnt_ff;
   logic head_load_ff, loading_ff, unloading_ff, rw_go_ff;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   fdsk_cmd_t cmd;
   logic setup, access, cmd_go, res_rd, data_wr, unsensed, cmd_bad, is_sense;
   logic [1:0] pick;
   logic pick_ok;
   logic [7:0] step_ms;
   logic [7:0] recal_limit;

   assign cmd = fdsk_cmd_t'(pwdata);
   assign setup = psel && !penable;
   assign access = psel && penable && pready_ff && accept_ff;
   assign cmd_go = access && pwrite && paddr == ADDR_CMD;
   assign res_rd = access && !pwrite && paddr == ADDR_RESULT;
   assign data_wr = access && pwrite && paddr == ADDR_DATA;
   assign unsensed = |pend_ff;
   assign is_sense = cmd.op == FDSK_OP_SENSE;
   assign cmd_bad = cmd.op[2] || (unsensed && !is_sense);
   assign step_ms = {3'h0, STEP_MS_MAX - {1'b0, ctrl_ff.step_interval_setting}};
   assign recal_limit = ctrl_ff.short_recal ? RECAL_LIMIT_SHORT : RECAL_LIMIT_LONG;

   always_comb begin
      pick = 2'h0;
      pick_ok = 1'b0;
      for (int d = NUM_DRIVES - 1; d >= 0; d--) begin
         if (pend_ff[d]) begin
            pick = 2'(d);
            pick_ok = 1'b1;
         end
      end
   end

   // Request bit high when idle, in result, or waiting in non-DMA mode
   logic host_request_bit, transfer_direction_bit, exec_bit;
   assign transfer_direction_bit = phase_ff == FDSK_PH_RESULT;
   assign exec_bit = phase_ff == FDSK_PH_EXEC && ctrl_ff.no_dma_select;
   assign host_request_bit = phase_ff != FDSK_PH_EXEC || (exec_bit && waiting_ff);

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Answer is decided in setup so the access phase always ends at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         accept_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= setup;
         if (setup) begin
            accept_ff <= 1'b1;
            prdata_ff <= 32'h0;
            case (paddr)
               ADDR_CTRL: prdata_ff <= ctrl_ff;
               ADDR_CMD: accept_ff <= !pwrite || (host_request_bit && !transfer_direction_bit);
               ADDR_MSR: begin
                  accept_ff <= !pwrite;
                  prdata_ff <= {24'h0, host_request_bit, transfer_direction_bit, exec_bit, phase_ff != FDSK_PH_IDLE,
                                seeking_ff};
               end
               ADDR_RESULT: begin
                  accept_ff <= !pwrite && transfer_direction_bit;
                  prdata_ff <= transfer_direction_bit ? result_ff : 32'h0;
               end
               ADDR_DATA: accept_ff <= pwrite && waiting_ff && host_request_bit;
               ADDR_PCN: begin
                  accept_ff <= !pwrite;
                  prdata_ff <= {pcn_ff[3], pcn_ff[2], pcn_ff[1], pcn_ff[0]};
               end
               default: accept_ff <= 1'b0;
            endcase
            pslverr_ff <= 1'b0;
         end else begin
            pslverr_ff <= 1'b0;
         end
      end
   end
   assign pslverr = pready_ff && !accept_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= fdsk_ctrl_t'(CTRL_RESET);
      end else if (access && pwrite && paddr == ADDR_CTRL) begin
         ctrl_ff <= fdsk_ctrl_t'(pwdata);
      end
   end

   // ----------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 18'h0;
         half_ff <= 1'b0;
         ms_tick_ff <= 1'b0;
      end else begin
         ms_tick_ff <= 1'b0;
         if (div_ff == 18'(MS_CYC - 1)) begin
            div_ff <= 18'h0;
            half_ff <= !half_ff;
            ms_tick_ff <= !ctrl_ff.half_clock || half_ff;
         end else begin
            div_ff <= div_ff + 18'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cnt_ff <= 5'h0;
         step_tick_ff <= 1'b0;
      end else begin
         step_tick_ff <= 1'b0;
         if (ms_tick_ff) begin
            if ({3'h0, step_cnt_ff} + 8'h1 >= step_ms) begin
               step_cnt_ff <= 5'h0;
               step_tick_ff <= 1'b1;
            end else begin
               step_cnt_ff <= step_cnt_ff + 5'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Seek and recalibrate engine
   // ----------------------------------------------------------------
   // Step pulse is one clock wide; a drive needing a wider pulse must stretch it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int d = 0; d < NUM_DRIVES; d++) begin
            pcn_ff[d] <= 8'h0;
            ncn_ff[d] <= 8'h0;
            cnt_ff[d] <= 8'h0;
         end
         active_ff <= 4'h0;
         recal_ff <= 4'h0;
         seeking_ff <= 4'h0;
         pend_ff <= 4'h0;
         abn_ff <= 4'h0;
         step_ff <= 4'h0;
         dir_ff <= 4'h0;
      end else begin
         step_ff <= 4'h0;
         if (cmd_go && !cmd_bad && is_sense && pick_ok) begin
            pend_ff[pick] <= 1'b0;
            seeking_ff[pick] <= 1'b0;
            abn_ff[pick] <= 1'b0;
         end
         for (int d = 0; d < NUM_DRIVES; d++) begin
            if (cmd_go && !cmd_bad && cmd.drive == 2'(d) &&
                (cmd.op == FDSK_OP_SEEK || cmd.op == FDSK_OP_RECAL)) begin
               active_ff[d] <= 1'b1;
               seeking_ff[d] <= 1'b1;
               recal_ff[d] <= cmd.op == FDSK_OP_RECAL;
               ncn_ff[d] <= cmd.new_cylinder;
               cnt_ff[d] <= 8'h0;
               if (cmd.op == FDSK_OP_RECAL) begin
                  pcn_ff[d] <= 8'h0;
                  dir_ff[d] <= 1'b0;
               end
            end else if (active_ff[d] && recal_ff[d]) begin
               if (track_zero[d]) begin
                  active_ff[d] <= 1'b0;
                  pend_ff[d] <= 1'b1;
               end else if (step_tick_ff && cnt_ff[d] == recal_limit) begin
                  active_ff[d] <= 1'b0;
                  pend_ff[d] <= 1'b1;
                  abn_ff[d] <= 1'b1;
               end else if (step_tick_ff) begin
                  step_ff[d] <= 1'b1;
                  cnt_ff[d] <= cnt_ff[d] + 8'h1;
               end
            end else if (active_ff[d]) begin
               if (pcn_ff[d] == ncn_ff[d]) begin
                  active_ff[d] <= 1'b0;
                  pend_ff[d] <= 1'b1;
               end else if (step_tick_ff) begin
                  step_ff[d] <= 1'b1;
                  dir_ff[d] <= pcn_ff[d] < ncn_ff[d];
                  pcn_ff[d] <= pcn_ff[d] < ncn_ff[d] ? pcn_ff[d] + 8'h1 : pcn_ff[d] - 8'h1;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Scan events
   // ----------------------------------------------------------------
   logic scan_end, ovr_exp, in_exec;
   logic [7:0] end_st0, end_st2, end_st1;
   assign in_exec = phase_ff == FDSK_PH_EXEC;
   assign ovr_exp = waiting_ff && ovr_cnt_ff == 16'h0;

   always_comb begin
      scan_end = 1'b0;
      end_st0 = 8'h0;
      end_st1 = 8'h0;
      end_st2 = st2_ff;
      if (in_exec) begin
         if (ovr_exp) begin
            scan_end = 1'b1;
            end_st0[7:6] = IC_ABNORMAL;
            end_st1[ST1_OR_BIT] = 1'b1;
         end else if (scan_ev.index_hole) begin
            scan_end = 1'b1;
            end_st0[7:6] = IC_ABNORMAL;
         end else if (scan_ev.sector_done && scan_ev.sector_deleted) begin
            end_st2[ST2_CM_BIT] = 1'b1;
            scan_end = !skip_ff || cur_ff == final_ff;
            end_st2[ST2_SN_BIT] = skip_ff && cur_ff == final_ff;
         end else if (scan_ev.sector_done && scan_ev.sector_hit) begin
            scan_end = 1'b1;
            end_st2[ST2_SH_BIT] = 1'b1;
         end else if (scan_ev.sector_done && cur_ff == final_ff) begin
            scan_end = 1'b1;
            end_st2[ST2_SN_BIT] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Command phases and results
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= FDSK_PH_IDLE;
         result_ff <= 32'h0;
         cur_ff <= 8'h0;
         final_ff <= 8'h0;
         inc_ff <= 2'h1;
         skip_ff <= 1'b0;
         st2_ff <= 8'h0;
         ready_pend_ff <= 1'b1;
      end else if (cmd_go) begin
         if (cmd_bad) begin
            phase_ff <= FDSK_PH_RESULT;
            result_ff <= {24'h0, ST0_INVALID};
         end else if (is_sense) begin
            phase_ff <= FDSK_PH_RESULT;
            if (pick_ok) begin
               result_ff <= {16'h0, pcn_ff[pick], abn_ff[pick] ? IC_ABNORMAL : IC_NORMAL,
                             1'b1, abn_ff[pick] && recal_ff[pick], 2'h0, pick};
            end else if (ready_pend_ff) begin
               ready_pend_ff <= 1'b0;
               result_ff <= {24'h0, IC_READY_CHG, 6'h0};
            end else begin
               result_ff <= {24'h0, ST0_INVALID};
            end
         end else if (cmd.op == FDSK_OP_SCAN) begin
            phase_ff <= FDSK_PH_EXEC;
            cur_ff <= cmd.new_cylinder;
            final_ff <= cmd.final_sector_number;
            inc_ff <= cmd.sector_increment_setting;
            skip_ff <= cmd.skip_deleted_option;
            st2_ff <= 8'h0;
         end
      end else if (res_rd) begin
         phase_ff <= FDSK_PH_IDLE;
      end else if (scan_end) begin
         phase_ff <= FDSK_PH_RESULT;
         result_ff <= {cur_ff, end_st2, end_st1, end_st0};
      end else if (in_exec && scan_ev.sector_done) begin
         st2_ff <= end_st2;
         cur_ff <= cur_ff + {6'h0, inc_ff};
      end
   end

   // ----------------------------------------------------------------
   // Comparison byte supply and overrun
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         waiting_ff <= 1'b0;
         ovr_cnt_ff <= 16'h0;
         comp_byte_ff <= 8'h0;
         comp_valid_ff <= 1'b0;
         dma_req_ff <= 1'b0;
      end else begin
         comp_valid_ff <= 1'b0;
         if (data_wr) begin
            waiting_ff <= 1'b0;
            comp_byte_ff <= pwdata[7:0];
            comp_valid_ff <= 1'b1;
         end else if (waiting_ff && ovr_cnt_ff != 16'h0) begin
            ovr_cnt_ff <= ovr_cnt_ff - 16'h1;
         end
         if (scan_end) begin
            waiting_ff <= 1'b0;
         end else if (in_exec && scan_ev.byte_due) begin
            waiting_ff <= 1'b1;
            ovr_cnt_ff <= ctrl_ff.mfm_mode ? 16'(MFM_OVR_CYC - 1) : 16'(FM_OVR_CYC - 1);
         end
         dma_req_ff <= waiting_ff && !data_wr && !ctrl_ff.no_dma_select && in_exec;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   // A new request in the same cycle as a data access still raises it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_irq_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         if (data_wr || res_rd) begin
            data_irq_ff <= 1'b0;
         end
         if (scan_end || (in_exec && scan_ev.byte_due && ctrl_ff.no_dma_select)) begin
            data_irq_ff <= 1'b1;
         end
         irq_ff <= data_irq_ff || unsensed || ready_pend_ff;
      end
   end

   // ----------------------------------------------------------------
   // Head load and unload timers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         head_load_ff <= 1'b0;
         loading_ff <= 1'b0;
         unloading_ff <= 1'b0;
         hl_cnt_ff <= 8'h0;
         hut_cnt_ff <= 8'h0;
         rw_go_ff <= 1'b0;
      end else begin
         rw_go_ff <= 1'b0;
         if (rw_req) begin
            unloading_ff <= 1'b0;
            head_load_ff <= 1'b1;
            loading_ff <= !head_load_ff;
            rw_go_ff <= head_load_ff;
            hl_cnt_ff <= {ctrl_ff.head_load_setting, 1'b0};
         end else if (loading_ff && ms_tick_ff) begin
            if (hl_cnt_ff <= 8'h1) begin
               loading_ff <= 1'b0;
               rw_go_ff <= 1'b1;
            end
            hl_cnt_ff <= hl_cnt_ff - 8'h1;
         end else if (rw_done) begin
            unloading_ff <= 1'b1;
            hut_cnt_ff <= {ctrl_ff.head_unload_setting, 4'h0};
         end else if (unloading_ff && ms_tick_ff) begin
            if (hut_cnt_ff <= 8'h1) begin
               unloading_ff <= 1'b0;
               head_load_ff <= 1'b0;
            end
            hut_cnt_ff <= hut_cnt_ff - 8'h1;
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign step_out = step_ff;
   assign dir_out = dir_ff;
   assign irq = irq_ff;
   assign dma_req = dma_req_ff;
   assign comp_byte = comp_byte_ff;
   assign comp_valid = comp_valid_ff;
   assign scan_sector = cur_ff;
   assign head_load = head_load_ff;
   assign rw_go = rw_go_ff;

endmodule

// *** core/fdsk_pkg.sv ***
// Constants, field layouts and command encodings for the disk sequencer.
// Assumes one 250 MHz clock and a 32-bit APB register port.
package fdsk_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int FM_OVR_NS = 27000;
   localparam int MFM_OVR_NS = 13000;
   // Longest times, so rounded down
   localparam int FM_OVR_CYCLES = FM_OVR_NS / CLK_PERIOD_NS;
   localparam int MFM_OVR_CYCLES = MFM_OVR_NS / CLK_PERIOD_NS;
   localparam logic [4:0] STEP_MS_MAX = 5'h10;
   localparam logic [7:0] RECAL_LIMIT_LONG = 8'hff;
   localparam logic [7:0] RECAL_LIMIT_SHORT = 8'h4d;
   localparam int NUM_DRIVES = 4;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_MSR = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0c;
   localparam logic [7:0] ADDR_DATA = 8'h10;
   localparam logic [7:0] ADDR_PCN = 8'h14;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Status bits
   // ----------------------------------------------------------------
   localparam logic [1:0] IC_NORMAL = 2'h0;
   localparam logic [1:0] IC_ABNORMAL = 2'h1;
   localparam logic [1:0] IC_INVALID = 2'h2;
   localparam logic [1:0] IC_READY_CHG = 2'h3;
   localparam int ST0_SE_BIT = 5;
   localparam int ST0_EC_BIT = 4;
   localparam int ST1_OR_BIT = 4;
   localparam int ST2_CM_BIT = 6;
   localparam int ST2_SH_BIT = 3;
   localparam int ST2_SN_BIT = 2;
   localparam logic [7:0] ST0_INVALID = 8'h80;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {FDSK_OP_SEEK, FDSK_OP_RECAL, FDSK_OP_SENSE, FDSK_OP_SCAN} fdsk_op_t;
   typedef enum logic [1:0] {FDSK_PH_IDLE, FDSK_PH_EXEC, FDSK_PH_RESULT} fdsk_phase_t;

   typedef struct packed {
      logic [4:0] pad_hi;
      logic skip_deleted_option;
      logic [1:0] sector_increment_setting;
      logic [7:0] final_sector_number;
      logic [7:0] new_cylinder;
      logic [2:0] pad_lo;
      logic [1:0] drive;
      logic [2:0] op;
   } fdsk_cmd_t;

   typedef struct packed {
      logic [11:0] pad_hi;
      logic short_recal;
      logic half_clock;
      logic mfm_mode;
      logic no_dma_select;
      logic pad_lo;
      logic [6:0] head_load_setting;
      logic [3:0] head_unload_setting;
      logic [3:0] step_interval_setting;
   } fdsk_ctrl_t;

   typedef struct packed {
      logic sector_done;
      logic sector_deleted;
      logic sector_hit;
      logic index_hole;
      logic byte_due;
   } fdsk_scan_ev_t;

endpackage

// *** sim/fdsk_seq_chk.sv ***
// Port-level assertions for the disk sequencer.
// Assumes it is bound onto fdsk_seq_core, all in the pclk domain.
`timescale 1ns/10ps
module fdsk_seq_chk
   import fdsk_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] step_out
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_pready_next: assert property (psel && !penable |=> pready)
      else $error("no zero-wait answer after setup");
   a_pready_one: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_rdy: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_unmapped_err: assert property (psel && !penable && (paddr > ADDR_PCN ||
      paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped access not refused");
   a_ro_write_err: assert property (psel && !penable && pwrite &&
      (paddr == ADDR_MSR || paddr == ADDR_PCN) |=> pslverr)
      else $error("status write not refused");
   a_result_wr_err: assert property (psel && !penable && pwrite &&
      paddr == ADDR_RESULT |=> pslverr)
      else $error("result write not refused");
   a_status_rd_ok: assert property (psel && !penable && !pwrite &&
      paddr == ADDR_MSR |=> !pslverr)
      else $error("status read refused");
   // Shortest step interval in the bench is far above eight cycles
   a_step_gap: assert property ((|step_out) |=> (step_out == 4'h0) [*8])
      else $error("step pulses too close");
endmodule

// *** sim/fdsk_drive_model.sv ***
// Four-drive head model: follows step and direction, reports track zero.
// Assumes steps are one-cycle pulses; stuck holds track zero low on purpose.
`timescale 1ns/10ps
module fdsk_drive_model (
   input wire logic pclk,
   input wire logic [3:0] step_out,
   input wire logic [3:0] dir_out,
   input wire logic [3:0] stuck,
   output logic [3:0] track_zero
);
   // Heads start off track zero so recalibrate really has to step
   int pos [4] = '{3, 3, 3, 3};
   always @(posedge pclk) begin
      for (int i = 0; i < 4; i++) begin
         if (step_out[i] && dir_out[i]) pos[i] <= pos[i] + 1;
         else if (step_out[i] && pos[i] > 0) pos[i] <= pos[i] - 1;
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) track_zero[i] = (pos[i] == 0) && !stuck[i];
   end
endmodule

// *** sim/test_floppy_seek_recal_sequencer.sv ***
// Self-checking bench: APB command sequences against the drive model.
// Assumes fdsk_pkg, fdsk_seq_core, fdsk_drive_model and fdsk_seq_chk compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_floppy_seek_recal_sequencer;
   import fdsk_pkg::*;
   logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, irq, head_load;
   logic rw_req = 0, rw_done = 0;
   logic [3:0] track_zero, step_out, dir_out, stuck = 0;
   int mismatches = 0, n_compared = 0, cycles = 0, n_step2 = 0;
   // ----------------------------------------------------------------
   // Design and drives
   // ----------------------------------------------------------------
   fdsk_seq_core #(.MS_CYC(20), .FM_OVR_CYC(40), .MFM_OVR_CYC(20)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .track_zero(track_zero), .scan_ev('0), .rw_req(rw_req), .rw_done(rw_done),
      .step_out(step_out), .dir_out(dir_out), .irq(irq), .dma_req(), .comp_byte(),
      .comp_valid(), .scan_sector(), .head_load(head_load), .rw_go());
   fdsk_drive_model u_drv (.pclk(pclk), .step_out(step_out), .dir_out(dir_out),
      .stuck(stuck), .track_zero(track_zero));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Ceiling well above the short recalibrate of some 1600 cycles
   always @(posedge pclk) begin
      cycles++;
      n_step2 <= n_step2 + int'(step_out[2]);
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic sense(input logic [7:0] e);
      apb(1'b1, ADDR_CMD, 32'h0000_0002);
      apb(1'b0, ADDR_RESULT, 32'h0);
      `CHK("status0", e, rd[7:0])
   endtask
   task automatic wait_irq();
      while (irq !== 1'b1) @(posedge pclk);
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("irq", 1'b1, irq)
      sense(8'hc0);
      apb(1'b1, ADDR_CTRL, 32'h0000_000f);
      rw_req <= 1'b1;
      @(posedge pclk);
      rw_req <= 1'b0;
      @(posedge pclk);
      `CHK("head load", 1'b1, head_load)
      rw_done <= 1'b1;
      @(posedge pclk);
      rw_done <= 1'b0;
      repeat (50) @(posedge pclk);
      `CHK("head unload", 1'b0, head_load)
      apb(1'b1, ADDR_MSR, 32'h0);
      apb(1'b1, ADDR_RESULT, 32'h0);
      apb(1'b1, ADDR_CMD, 32'h0000_0001);
      wait_irq();
      sense(8'h20);
      apb(1'b1, ADDR_CMD, 32'h0000_0508);
      apb(1'b0, ADDR_MSR, 32'h0);
      `CHK("msr seek", 5'h02, rd[4:0])
      wait_irq();
      apb(1'b0, ADDR_MSR, 32'h0);
      `CHK("msr held", 1'b1, rd[1])
      sense(8'h21);
      apb(1'b0, ADDR_MSR, 32'h0);
      `CHK("msr clear", 1'b0, rd[1])
      apb(1'b0, ADDR_PCN, 32'h0);
      `CHK("pcn1", 8'h05, rd[15:8])
      `CHK("head1", 8, u_drv.pos[1])
      apb(1'b1, ADDR_CMD, 32'h0000_0208);
      wait_irq();
      sense(8'h21);
      apb(1'b0, ADDR_PCN, 32'h0);
      `CHK("pcn", 16'h0200, rd[15:0])
      `CHK("head1", 5, u_drv.pos[1])
      apb(1'b1, ADDR_CMD, 32'h0000_0004);
      apb(1'b0, ADDR_MSR, 32'h0);
      `CHK("msr invalid", 2'h3, rd[7:6])
      apb(1'b0, ADDR_RESULT, 32'h0);
      `CHK("invalid", ST0_INVALID, rd[7:0])
      `CHK("irq", 1'b0, irq)
      apb(1'b1, ADDR_CMD, 32'h0000_0100);
      wait_irq();
      apb(1'b1, ADDR_CMD, 32'h0000_0001);
      apb(1'b0, ADDR_RESULT, 32'h0);
      `CHK("unsensed", ST0_INVALID, rd[7:0])
      sense(8'h20);
      stuck <= 4'h4;
      apb(1'b1, ADDR_CTRL, 32'h0008_000f);
      apb(1'b1, ADDR_CMD, 32'h0000_0011);
      wait_irq();
      sense(8'h72);
      `CHK("steps", 77, n_step2)
      results();
   end
endmodule
bind fdsk_seq_core fdsk_seq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .step_out(step_out));
